// >>> hw/lrc_ladder_reference_control.v
// Ladder reference control register with Avalon-MM slave and tap mapping outputs.
`include "lrc_map.vh"
module lrc_ladder_reference_control (
   // Clock and reset.
   input wire clk,
   input wire rst,
   // Avalon-MM slave.
   input wire [`LRC_ADDR_W-1:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output wire [31:0] avs_readdata,
   output wire avs_waitrequest,
   output wire [1:0] avs_response,
   // Port A direction register, bit 2 set means the pin is an input.
   input wire [7:0] port_a_direction,
   // Analog ladder controls.
   output wire ladder_power_enable,
   output wire reference_output_pin_connect,
   output wire range_low,
   output wire [3:0] tap_select,
   output wire [5:0] ladder_numerator,
   output wire [5:0] ladder_denominator
);
   // Handshake states.
   localparam [0:0] ST_IDLE = 1'b0;
   localparam [0:0] ST_ANSWER = 1'b1;

   // Avalon-MM response codes.
   localparam [1:0] RESP_OKAY = 2'h0;
   localparam [1:0] RESP_SLAVE_ERROR = 2'h2;

   // Registers.
   reg state_ff;
   reg [7:0] reference_control_ff;
   reg dir_meta_ff;
   reg dir_sync_ff;
   reg [31:0] readdata_ff;
   reg waitrequest_ff;
   reg [1:0] response_ff;
   reg power_enable_ff;
   reg pin_connect_ff;
   reg range_low_ff;
   reg [3:0] tap_select_ff;
   reg [5:0] numerator_ff;
   reg [5:0] denominator_ff;

   // Next values and decodes.
   reg nxt_state;
   reg take;
   reg [7:0] nxt_reference_control;
   reg [31:0] nxt_readdata;
   reg [1:0] nxt_response;
   reg [3:0] nxt_tap;
   reg [5:0] nxt_numerator;
   reg [5:0] nxt_denominator;
   wire hit;
   wire write_take;
   wire read_take;
   wire nxt_waitrequest;
   wire nxt_power_enable;
   wire nxt_pin_connect;
   wire nxt_range_low;

   // Direction comes from another register file, so it passes two flip-flops before any logic reads it.
   always @(posedge clk) begin
      if (rst) begin
         dir_meta_ff <= 1'b0;
         dir_sync_ff <= 1'b0;
      end else begin
         dir_meta_ff <= port_a_direction[`LRC_DIR_BIT];
         dir_sync_ff <= dir_meta_ff;
      end
   end

   // A request is taken only from idle, so a request still held in its answer cycle is not taken twice.
   always @* begin
      nxt_state = state_ff;
      take = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (avs_read | avs_write) begin
               take = 1'b1;
               nxt_state = ST_ANSWER;
            end
         end
         ST_ANSWER: begin
            nxt_state = ST_IDLE;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // Address decode; a write needs the low byte lane because the register lives there.
   assign hit = (avs_address == `LRC_REF_CTRL_ADDR);
   assign write_take = take & avs_write & hit & avs_byteenable[0];
   assign read_take = take & avs_read & hit;

   // Bit 4 has no storage, so it is dropped on the way in and reads back as zero.
   always @* begin
      nxt_reference_control = reference_control_ff;
      if (write_take) begin
         nxt_reference_control = avs_writedata[7:0] & `LRC_WRITE_MASK;
      end
   end

   // Read data and response stand only in the answer cycle and are zero otherwise.
   always @* begin
      nxt_readdata = 32'h0000_0000;
      nxt_response = RESP_OKAY;
      if (read_take) begin
         nxt_readdata = {24'h00_0000, reference_control_ff};
      end
      if (take & ~hit) begin
         nxt_response = RESP_SLAVE_ERROR;
      end
   end

   // The controls follow the value being stored, so a write shows in its own answer cycle.
   assign nxt_waitrequest = ~take;
   assign nxt_power_enable = nxt_reference_control[`LRC_BIT_POWER];
   assign nxt_pin_connect = nxt_reference_control[`LRC_BIT_PIN_OE] & dir_sync_ff;
   assign nxt_range_low = nxt_reference_control[`LRC_BIT_RANGE_LOW];

   // The level is handed over as a fraction of the supply; the high range adds its quarter as 8/32.
   always @* begin
      nxt_tap = nxt_reference_control[`LRC_TAP_HI:`LRC_TAP_LO];
      if (nxt_range_low) begin
         nxt_numerator = {2'h0, nxt_tap};
         nxt_denominator = `LRC_DEN_LOW;
      end else begin
         nxt_numerator = `LRC_TAP_TOP_HIGH + {2'h0, nxt_tap};
         nxt_denominator = `LRC_DEN_HIGH;
      end
   end

   // Handshake state.
   always @(posedge clk) begin
      if (rst) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Control register.
   always @(posedge clk) begin
      if (rst) begin
         reference_control_ff <= `LRC_REF_CTRL_RESET;
      end else begin
         reference_control_ff <= nxt_reference_control;
      end
   end

   // Waitrequest stays high in reset and idle and drops for the single answer cycle.
   always @(posedge clk) begin
      if (rst) begin
         waitrequest_ff <= 1'b1;
      end else begin
         waitrequest_ff <= nxt_waitrequest;
      end
   end

   // Read data and response of the answer cycle.
   always @(posedge clk) begin
      if (rst) begin
         readdata_ff <= 32'h0000_0000;
         response_ff <= RESP_OKAY;
      end else begin
         readdata_ff <= nxt_readdata;
         response_ff <= nxt_response;
      end
   end

   // Power and range; reset leaves the ladder off and in the high range.
   always @(posedge clk) begin
      if (rst) begin
         power_enable_ff <= 1'b0;
         range_low_ff <= 1'b0;
      end else begin
         power_enable_ff <= nxt_power_enable;
         range_low_ff <= nxt_range_low;
      end
   end

   // Pin connection; reset keeps the reference off the pin.
   always @(posedge clk) begin
      if (rst) begin
         pin_connect_ff <= 1'b0;
      end else begin
         pin_connect_ff <= nxt_pin_connect;
      end
   end

   // Tap select.
   always @(posedge clk) begin
      if (rst) begin
         tap_select_ff <= 4'h0;
      end else begin
         tap_select_ff <= nxt_tap;
      end
   end

   // Level fraction; the reset level is tap zero of the high range.
   always @(posedge clk) begin
      if (rst) begin
         numerator_ff <= `LRC_TAP_TOP_HIGH;
         denominator_ff <= `LRC_DEN_HIGH;
      end else begin
         numerator_ff <= nxt_numerator;
         denominator_ff <= nxt_denominator;
      end
   end

   // Bus outputs.
   assign avs_readdata = readdata_ff;
   assign avs_waitrequest = waitrequest_ff;
   assign avs_response = response_ff;

   // Ladder outputs.
   assign ladder_power_enable = power_enable_ff;
   assign reference_output_pin_connect = pin_connect_ff;
   assign range_low = range_low_ff;
   assign tap_select = tap_select_ff;
   assign ladder_numerator = numerator_ff;
   assign ladder_denominator = denominator_ff;
endmodule // lrc_ladder_reference_control

// >>> hw/lrc_map.vh
// Register map, field positions and reset values of the ladder reference control block.
`ifndef LRC_MAP_VH
`define LRC_MAP_VH
`define LRC_ADDR_W 8
`define LRC_REF_CTRL_ADDR 8'h9F
`define LRC_REF_CTRL_RESET 8'h00
`define LRC_BIT_POWER 7
`define LRC_BIT_PIN_OE 6
`define LRC_BIT_RANGE_LOW 5
`define LRC_TAP_HI 3
`define LRC_TAP_LO 0
`define LRC_WRITE_MASK 8'hEF
`define LRC_DIR_BIT 2
`define LRC_TAP_TOP_HIGH 6'h08
`define LRC_DEN_LOW 6'h18
`define LRC_DEN_HIGH 6'h20
`endif

// >>> testbench/lrc_assertions.sv
// Checker for the ladder reference control block.
module lrc_assertions (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Avalon-MM slave.
   input wire logic [7:0] avs_address,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   // Port A direction.
   input wire logic [7:0] port_a_direction,
   // Ladder controls.
   input wire logic ladder_power_enable,
   input wire logic reference_output_pin_connect,
   input wire logic range_low,
   input wire logic [3:0] tap_select,
   input wire logic [5:0] ladder_numerator,
   input wire logic [5:0] ladder_denominator
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // The outputs follow a write in its answer cycle, so the request is still visible there.
   wire w = avs_write && !avs_waitrequest && avs_address == 8'h9F && avs_byteenable[0];
   a_power_bit: assert property (w |-> ladder_power_enable == avs_writedata[7]) else $error("power");
   a_range_bit: assert property (w |-> range_low == avs_writedata[5]) else $error("range");
   a_tap_field: assert property (w |-> tap_select == avs_writedata[3:0]) else $error("tap");
   a_low_level: assert property (range_low |-> ladder_numerator == tap_select && ladder_denominator == 6'h18)
      else $error("low");
   a_high_level: assert property (!range_low |-> ladder_numerator == tap_select + 6'h08 && ladder_denominator == 6'h20)
      else $error("high");
   a_bit4_zero: assert property (!avs_waitrequest |-> !avs_readdata[4]) else $error("bit4");
   a_reset_clear: assert property (disable iff (1'b0) rst |=> {ladder_power_enable, range_low, tap_select} == 6'h00)
      else $error("reset");
   a_pin_gate: assert property (reference_output_pin_connect |-> $past(port_a_direction[2], 3))
      else $error("pin");
endmodule // lrc_assertions
bind lrc_ladder_reference_control lrc_assertions chk (.*);

// >>> testbench/tb_lrc_ladder_reference_control.sv
// Testbench for the ladder reference control block.
module tb_lrc_ladder_reference_control;
   timeunit 1ns / 1ns;
   logic clk = 0, rst = 1, avs_read = 0, avs_write = 0;
   logic [7:0] avs_address = 8'h00, port_a_direction = 8'h04;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hF;
   wire [31:0] avs_readdata;
   wire avs_waitrequest, reference_output_pin_connect, ladder_power_enable, range_low;
   wire [1:0] avs_response;
   wire [3:0] tap_select;
   wire [5:0] ladder_numerator, ladder_denominator;
   int err_count = 0, n_compared = 0;
   lrc_ladder_reference_control dut (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
      .port_a_direction(port_a_direction), .ladder_power_enable(ladder_power_enable),
      .reference_output_pin_connect(reference_output_pin_connect), .range_low(range_low),
      .tap_select(tap_select), .ladder_numerator(ladder_numerator), .ladder_denominator(ladder_denominator));
   always #5 clk = ~clk;
   task report_and_stop;
      $display("%0d compared, %0d failed", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task ck(string s, logic [31:0] e, g);
      n_compared++;
      err_count += int'(g !== e);
      if (g !== e) $display("CHECK FAILED %s exp %h got %h", s, e, g);
   endtask
   // A read carries its expected value in d; the wait is cut short by the watchdog only.
   task bus(bit w, bit [7:0] a, d);
      @(posedge clk);
      {avs_write, avs_read, avs_address, avs_writedata} <= {w, !w, a, 24'h0, d};
      do @(posedge clk); while (avs_waitrequest !== 1'b0);
      if (!w) ck("readdata", {24'h0, d}, avs_readdata);
      ck("response", (a == 8'h9F) ? 32'h0 : 32'h2, avs_response);
      {avs_write, avs_read} <= 2'h0;
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 0;
      bus(0, 8'h9F, 8'h00);
      bus(1, 8'h9F, 8'hFF);
      ck("numerator", 32'h0F, ladder_numerator);
      ck("denominator", 32'h18, ladder_denominator);
      ck("range", 1, range_low);
      bus(0, 8'h9F, 8'hEF);
      bus(1, 8'h9F, 8'h4B);
      ck("numerator", 32'h13, ladder_numerator);
      ck("denominator", 32'h20, ladder_denominator);
      ck("pin", 1, reference_output_pin_connect);
      $display("register test done");
      port_a_direction <= 8'h00;
      repeat (2) @(posedge clk);
      ck("pin", 1, reference_output_pin_connect);
      repeat (2) @(posedge clk);
      ck("pin", 0, reference_output_pin_connect);
      port_a_direction <= 8'h04;
      $display("pin test done");
      avs_byteenable <= 4'h0;
      bus(1, 8'h9F, 8'h00);
      avs_byteenable <= 4'hF;
      bus(1, 8'hA0, 8'hFF);
      bus(0, 8'h9F, 8'h4B);
      ck("pin", 1, reference_output_pin_connect);
      bus(1, 8'h9F, 8'hA6);
      ck("power", 1, ladder_power_enable);
      ck("pin", 0, reference_output_pin_connect);
      bus(0, 8'h9F, 8'hA6);
      $display("bus error test done");
      report_and_stop;
   end
   initial begin
      #20us err_count++;
      report_and_stop;
   end
endmodule // tb_lrc_ladder_reference_control
